// ---- core/byte_alu_add_and_bitops.sv ----
/*
 Execution slice for add, add-with-carry, AND, bit-AND and bit-compare,
 plus the zero/equal condition test. Assumes the sequencer presents one
 instruction with start_i and waits for done_o before the next.
*/
`timescale 1ns/10ps
`default_nettype none
`include "byte_alu_cfg.svh"

module byte_alu_add_and_bitops
    import byte_alu_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Instruction request
    input wire logic start_i,
    input wire alu_req_t req_i,
    // Condition query
    input wire logic [3:0] cc_i,
    // Results
    output logic busy_o,
    output logic done_o,
    output logic [7:0] result_o,
    output logic wr_dst_o,
    output logic bad_op_o,
    output var flags_t flags_o,
    output logic [3:0] reg_addr_o,
    output logic cc_true_o
);
    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    alu_state_t state_q, state_d;
    alu_req_t req_q, req_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] result_q, result_d;
    logic wr_q, wr_d, done_q, done_d, bad_q, bad_d;
    flags_t flags_q, flags_d;
    logic [3:0] raddr_q, raddr_d;
    logic cc_q, cc_d;
    logic busy_q, busy_d;
    alu_rsp_t rsp;
    logic known;

    byte_alu_compute u_compute (
        .req_i(req_q),
        .rsp_o(rsp),
        .known_o(known)
    );

    always_comb begin
        state_d = state_q;
        req_d = req_q;
        cnt_d = cnt_q;
        result_d = result_q;
        wr_d = 1'b0;
        done_d = 1'b0;
        bad_d = bad_q;
        flags_d = flags_q;
        raddr_d = raddr_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start_i) begin
                    req_d = req_i;
                    raddr_d = req_i.byte2[`BYTE2_REG_HI:`BYTE2_REG_LO];
                    // Only the rr short form of each range is 4 cycles
                    if (req_i.opcode[3:0] == `OPC_LOW_RR
                        && req_i.opcode != `OPC_BAND
                        && req_i.opcode != `OPC_BIT_CMP) begin
                        cnt_d = `CYC_SHORT - 4'h2;
                    end else begin
                        cnt_d = `CYC_LONG - 4'h2;
                    end
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (cnt_q == 4'h0) begin
                    state_d = ST_DONE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ST_DONE: begin
                // Writeback and flags on the last cycle of the instruction
                result_d = rsp.result;
                wr_d = rsp.wr_dst & known;
                flags_d = rsp.flags;
                bad_d = ~known;
                done_d = 1'b1;
                state_d = ST_IDLE;
            end
        endcase
        // Zero and equal share one encoding, so one test covers both
        unique case (cc_i)
            `CC_ZERO: cc_d = flags_d.z;
            `CC_NOT_ZERO: cc_d = ~flags_d.z;
            default: cc_d = 1'b0;
        endcase
        // Registered so the sequencer sees a glitch-free level
        busy_d = (state_d != ST_IDLE) | done_d;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            req_q <= '0;
            cnt_q <= 4'h0;
            result_q <= 8'h00;
            wr_q <= 1'b0;
            done_q <= 1'b0;
            bad_q <= 1'b0;
            flags_q <= '0;
            raddr_q <= 4'h0;
            cc_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            cnt_q <= cnt_d;
            result_q <= result_d;
            wr_q <= wr_d;
            done_q <= done_d;
            bad_q <= bad_d;
            flags_q <= flags_d;
            raddr_q <= raddr_d;
            cc_q <= cc_d;
            busy_q <= busy_d;
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;
    assign result_o = result_q;
    assign wr_dst_o = wr_q;
    assign bad_op_o = bad_q;
    assign flags_o = flags_q;
    assign reg_addr_o = raddr_q;
    assign cc_true_o = cc_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    int unsigned span_q;
    always_ff @(posedge mclk_i) begin
        if (rst_i || (state_q == ST_IDLE && start_i)) span_q <= 0;
        else span_q <= span_q + 1;
    end

    instr_len_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        done_q |-> (span_q == 32'd4 || span_q == 32'd6))
        else $error("instruction length not 4 or 6 cycles");

    // done_q rises on the 4th edge after the take, seen high on the 5th
    short_form_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (state_q == ST_IDLE && start_i && req_i.opcode == `OPC_ADD_FIRST)
        |-> ##5 done_q)
        else $error("register add not done in 4 cycles");

    bit_len_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (state_q == ST_IDLE && start_i && req_i.opcode == `OPC_BIT_CMP)
        |-> ##7 done_q)
        else $error("bit compare not done in 6 cycles");

    adc_sum_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (done_q && req_q.opcode >= `OPC_ADC_FIRST
         && req_q.opcode <= `OPC_ADC_LAST)
        |-> {flags_q.c, result_q} == {1'b0, req_q.dst}
            + {1'b0, req_q.src} + {8'h00, req_q.flags.c})
        else $error("add with carry sum or carry wrong");

    add_carry_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (done_q && req_q.opcode >= `OPC_ADD_FIRST
         && req_q.opcode <= `OPC_ADD_LAST)
        |-> {flags_q.c, result_q}
            == {1'b0, req_q.dst} + {1'b0, req_q.src})
        else $error("add sum or carry wrong");

    add_overflow_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (done_q && wr_q && req_q.opcode <= `OPC_ADC_LAST)
        |-> flags_q.v == (req_q.dst[7] == req_q.src[7]
            && result_q[7] != req_q.dst[7]))
        else $error("add overflow flag wrong");

    // Carry into bit 4 recovered from the sum bit and both operand bits
    half_carry_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (done_q && wr_q && req_q.opcode <= `OPC_ADC_LAST)
        |-> flags_q.h == (result_q[4] ^ req_q.dst[4] ^ req_q.src[4]))
        else $error("add half carry flag wrong");

    add_decimal_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (done_q && wr_q && req_q.opcode <= `OPC_ADC_LAST)
        |-> !flags_q.d && flags_q.z == (result_q == 8'h00)
            && flags_q.s == result_q[7])
        else $error("add zero, sign or decimal flag wrong");

    and_keep_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (done_q && req_q.opcode >= `OPC_AND_FIRST
         && req_q.opcode <= `OPC_AND_LAST)
        |-> !flags_q.v && flags_q.c == req_q.flags.c
            && flags_q.h == req_q.flags.h
            && result_q == (req_q.dst & req_q.src))
        else $error("logical and result or flags wrong");

    band_other_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (done_q && req_q.opcode == `OPC_BAND)
        |-> $countones(result_q ^ req_q.dst) <= 1 && !flags_q.s)
        else $error("bit and touched other bits");

    band_zero_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (done_q && req_q.opcode == `OPC_BAND)
        |-> flags_q.z == !(req_q.byte2[`BYTE2_FORM]
            ? result_q[req_q.byte2[`BYTE2_BIT_HI:`BYTE2_BIT_LO]]
            : result_q[0]))
        else $error("bit and zero flag wrong");

    cmp_nowrite_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (done_q && req_q.opcode == `OPC_BIT_CMP)
        |-> !wr_q && flags_q.h == req_q.flags.h
            && flags_q.z == (req_q.dst[0]
            == req_q.src[req_q.byte2[`BYTE2_BIT_HI:`BYTE2_BIT_LO]]))
        else $error("bit compare wrote or set flags wrong");

    reg_addr_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (state_q == ST_IDLE && start_i)
        |=> raddr_q == req_q.byte2[`BYTE2_REG_HI:`BYTE2_REG_LO])
        else $error("register address field not taken");

    zero_cc_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (cc_i == `CC_ZERO) |=> cc_q == flags_q.z)
        else $error("zero condition does not follow zero flag");

endmodule // byte_alu_add_and_bitops
`default_nettype wire

// ---- core/byte_alu_cfg.svh ----
/*
 Constants of the byte ALU slice: opcodes, operand byte fields, flag bit
 positions and cycle counts. Assumes nothing beyond a preprocessor.
*/
`ifndef BYTE_ALU_CFG_SVH
`define BYTE_ALU_CFG_SVH

// Opcode ranges
`define OPC_ADC_FIRST 8'h12
`define OPC_ADC_LAST 8'h16
`define OPC_ADD_FIRST 8'h02
`define OPC_ADD_LAST 8'h06
`define OPC_AND_FIRST 8'h52
`define OPC_AND_LAST 8'h56
`define OPC_BAND 8'h67
`define OPC_BIT_CMP 8'h17

// Register-register short form, the only 4-cycle form in each range
`define OPC_LOW_RR 4'h2

// Second byte of the bit formats
`define BYTE2_REG_HI 7
`define BYTE2_REG_LO 4
`define BYTE2_BIT_HI 3
`define BYTE2_BIT_LO 1
`define BYTE2_FORM 0

// Flag vector positions {c,z,s,v,d,h}
`define FLG_C 5
`define FLG_Z 4
`define FLG_S 3
`define FLG_V 2
`define FLG_D 1
`define FLG_H 0

// Instruction length in core cycles
`define CYC_SHORT 4'h4
`define CYC_LONG 4'h6

// Condition code that tests the zero flag (zero and equal alike)
`define CC_ZERO 4'h6
`define CC_NOT_ZERO 4'hE

`endif

// ---- core/byte_alu_pkg.sv ----
/*
 Types shared by the byte ALU slice. Assumes byte_alu_cfg.svh for numbers.
*/
package byte_alu_pkg;

    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
    } flags_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] dst;
        logic [7:0] src;
        logic [7:0] byte2;
        flags_t flags;
    } alu_req_t;

    typedef struct packed {
        logic [7:0] result;
        logic wr_dst;
        flags_t flags;
    } alu_rsp_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_DONE = 3'b100
    } alu_state_t;

endpackage

// ---- core/byte_alu_compute.sv ----
/*
 Combinational result and flag computation for one instruction.
 Assumes a registered request from byte_alu_add_and_bitops.
*/
`timescale 1ns/10ps
`default_nettype none
`include "byte_alu_cfg.svh"

module byte_alu_compute
    import byte_alu_pkg::*;
(
    // Request
    input wire alu_req_t req_i,
    // Answer
    output var alu_rsp_t rsp_o,
    output logic known_o
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic cin;
    logic [2:0] bidx;
    logic form;
    logic bitv;
    logic [7:0] r;
    flags_t f;

    always_comb begin
        cin = 1'b0;
        bidx = req_i.byte2[`BYTE2_BIT_HI:`BYTE2_BIT_LO];
        form = req_i.byte2[`BYTE2_FORM];
        bitv = 1'b0;
        r = req_i.dst;
        f = req_i.flags;
        known_o = 1'b1;
        rsp_o.wr_dst = 1'b0;
        if (req_i.opcode >= `OPC_ADC_FIRST
            && req_i.opcode <= `OPC_ADC_LAST) begin
            cin = req_i.flags.c;
        end
        sum = {1'b0, req_i.dst} + {1'b0, req_i.src} + {8'h00, cin};
        nib = {1'b0, req_i.dst[3:0]} + {1'b0, req_i.src[3:0]} + {4'h0, cin};
        if ((req_i.opcode >= `OPC_ADC_FIRST && req_i.opcode <= `OPC_ADC_LAST)
            || (req_i.opcode >= `OPC_ADD_FIRST
                && req_i.opcode <= `OPC_ADD_LAST)) begin
            r = sum[7:0];
            rsp_o.wr_dst = 1'b1;
            f.c = sum[8];
            f.v = (req_i.dst[7] == req_i.src[7])
                  && (r[7] != req_i.dst[7]);
            f.h = nib[4];
            f.z = (r == 8'h00);
            f.s = r[7];
            f.d = 1'b0;
        end else if (req_i.opcode >= `OPC_AND_FIRST
                     && req_i.opcode <= `OPC_AND_LAST) begin
            r = req_i.dst & req_i.src;
            rsp_o.wr_dst = 1'b1;
            f.z = (r == 8'h00);
            f.s = r[7];
            f.v = 1'b0;
        end else if (req_i.opcode == `OPC_BAND) begin
            // Form 0: dst(0) &= src(b); form 1: dst(b) &= src(0)
            if (!form) begin
                bitv = req_i.dst[0] & req_i.src[bidx];
                r[0] = bitv;
            end else begin
                bitv = req_i.dst[bidx] & req_i.src[0];
                r[bidx] = bitv;
            end
            rsp_o.wr_dst = 1'b1;
            f.z = ~bitv;
            f.s = 1'b0;
            f.v = 1'b0; // Undefined; held low for repeatability
        end else if (req_i.opcode == `OPC_BIT_CMP) begin
            f.z = (req_i.dst[0] == req_i.src[bidx]);
            f.s = 1'b0;
            f.v = 1'b0;
        end else begin
            known_o = 1'b0;
        end
        rsp_o.result = r;
        rsp_o.flags = f;
    end

endmodule // byte_alu_compute
`default_nettype wire

// ---- sim/byte_alu_add_and_bitops_test.sv ----
/*
 Self-checking bench for byte_alu_add_and_bitops: a table of instructions,
 then a refused start and a reset in mid-run.
 Assumes the core package and a 40 MHz core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module byte_alu_add_and_bitops_test import byte_alu_pkg::*;
;
    typedef struct {
        logic [7:0] op, d, s, b2;
        flags_t fi;
        logic [7:0] res;
        logic wr;
        flags_t fo;
        int cyc;
    } row_t;

    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic start_i = 1'b0;
    alu_req_t req_i = '0;
    logic [3:0] cc_i = 4'h0;
    logic busy_o, done_o, wr_dst_o, bad_op_o, cc_true_o;
    logic [7:0] result_o;
    flags_t flags_o;
    logic [3:0] reg_addr_o;
    int miscompares = 0;
    int compares = 0;
    row_t rows[$];

    byte_alu_add_and_bitops dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .start_i(start_i), .req_i(req_i),
        .cc_i(cc_i), .busy_o(busy_o), .done_o(done_o),
        .result_o(result_o), .wr_dst_o(wr_dst_o), .bad_op_o(bad_op_o),
        .flags_o(flags_o), .reg_addr_o(reg_addr_o), .cc_true_o(cc_true_o)
    );

    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h, expected %h", $time,
                     seen, exp);
        end
    endtask

    task report_and_stop();
        $display("Compares %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task add(input logic [7:0] op, d, s, b2, input flags_t fi,
             input logic [7:0] res, input logic wr, input flags_t fo,
             input int cyc);
        rows.push_back('{op, d, s, b2, fi, res, wr, fo, cyc});
    endtask

    task cc_try(input logic [3:0] c, input logic e);
        @(posedge mclk_i);
        cc_i <= c;
        repeat (2) @(posedge mclk_i);
        #1 check(cc_true_o, e);
        check({busy_o, done_o, wr_dst_o}, 3'h0);
    endtask

    // Poke keeps start high one cycle into the instruction; it must be
    // ignored, so the answer still belongs to the first request.
    task go(input row_t r, input logic poke);
        int n;
        @(posedge mclk_i);
        start_i <= 1'b1;
        req_i <= '{r.op, r.d, r.s, r.b2, r.fi};
        @(posedge mclk_i);
        start_i <= poke;
        req_i.opcode <= 8'h52;
        #1 check(busy_o, 1'b1);
        for (n = 1; n <= 20; n++) begin
            @(posedge mclk_i);
            start_i <= 1'b0;
            #1;
            if (done_o === 1'b1)
                break;
        end
        if (n > 20) begin
            miscompares++;
            report_and_stop();
        end
        check(8'(n), 8'(r.cyc));
        check(wr_dst_o, r.wr);
        check(bad_op_o, r.op == 8'h07);
        if (r.wr)
            check(result_o, r.res);
        check(flags_o, r.fo);
        check(reg_addr_o, r.b2[7:4]);
        cc_try(4'h6, r.fo.z);
        cc_try(4'hE, ~r.fo.z);
        cc_try(4'h8, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1 check(busy_o, 1'b0);
        check(done_o, 1'b0);
        check(result_o, 8'h00);
        check(flags_o, 6'h00);
        $display("Reset test done");
        add(8'h12,8'h10,8'h03,8'h00,6'h22,8'h14,1'h1,6'h00,4);
        add(8'h13,8'h01,8'h02,8'h00,6'h00,8'h03,1'h1,6'h00,6);
        add(8'h14,8'h20,8'h03,8'h00,6'h20,8'h24,1'h1,6'h00,6);
        add(8'h15,8'h0F,8'h00,8'h00,6'h20,8'h10,1'h1,6'h01,6);
        add(8'h16,8'hFF,8'h00,8'h00,6'h20,8'h00,1'h1,6'h31,6);
        add(8'h02,8'h7F,8'h01,8'h00,6'h22,8'h80,1'h1,6'h0D,4);
        add(8'h03,8'h01,8'hFF,8'h00,6'h00,8'h00,1'h1,6'h31,6);
        add(8'h04,8'h12,8'h03,8'h00,6'h2D,8'h15,1'h1,6'h00,6);
        add(8'h05,8'hC0,8'hC0,8'h00,6'h00,8'h80,1'h1,6'h28,6);
        add(8'h06,8'h80,8'h80,8'h00,6'h00,8'h00,1'h1,6'h34,6);
        add(8'h52,8'h12,8'h03,8'h00,6'h3F,8'h02,1'h1,6'h23,4);
        add(8'h53,8'hF0,8'h80,8'h00,6'h04,8'h80,1'h1,6'h08,6);
        add(8'h54,8'h21,8'h02,8'h00,6'h23,8'h00,1'h1,6'h33,6);
        add(8'h55,8'h21,8'h25,8'h00,6'h00,8'h21,1'h1,6'h00,6);
        add(8'h56,8'hFF,8'h0F,8'h00,6'h10,8'h0F,1'h1,6'h00,6);
        add(8'h67,8'h07,8'h05,8'h12,6'h2B,8'h06,1'h1,6'h33,6);
        add(8'h67,8'hFF,8'hFE,8'h4B,6'h00,8'hDF,1'h1,6'h10,6);
        add(8'h67,8'h80,8'h01,8'hAF,6'h08,8'h80,1'h1,6'h00,6);
        add(8'h17,8'h07,8'h01,8'h12,6'h3F,8'h07,1'h0,6'h23,6);
        add(8'h17,8'h06,8'h02,8'h34,6'h00,8'h06,1'h0,6'h10,6);
        add(8'h07,8'h01,8'h02,8'h20,6'h2A,8'h00,1'h0,6'h2A,6);
        foreach (rows[i])
            go(rows[i], 1'b0);
        $display("Table test done");
        go(rows[8], 1'b1);
        $display("Refused start test done");
        // ------------------------------------------------------------
        // Reset in mid-instruction, then recovery
        // ------------------------------------------------------------
        @(posedge mclk_i);
        start_i <= 1'b1;
        req_i <= '{8'h04, 8'h12, 8'h03, 8'h00, 6'h00};
        @(posedge mclk_i);
        start_i <= 1'b0;
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1 check(busy_o, 1'b0);
        check(result_o, 8'h00);
        go(rows[0], 1'b0);
        $display("Mid-run reset test done");
        report_and_stop();
    end
endmodule // byte_alu_add_and_bitops_test
`default_nettype wire
